// ### hw/spe_dev.sv
// Memory end: serial target, page buffer, timed write and byte array
`default_nettype none
module spe_dev #(
   parameter int unsigned WR_CYC = spe_pkg::WR_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Serial link
   spe_if.dev        lnk,
   // User side
   input  wire logic pwr_fail,
   output logic      busy
);
   import spe_pkg::*;

   logic [4:0] raw_in;
   logic [4:0] syn;
   logic       sck_s, cs_n_s, si_s, hold_n_s, pf_s;

   // Active-low pins pass inverted, so the synchroniser's reset reads as idle
   assign raw_in = {pwr_fail, ~lnk.hold_n, lnk.si, ~lnk.cs_n, lnk.sck};
   spe_sync #(.W(5)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (raw_in),
      .q       (syn)
   );
   assign sck_s    = syn[0];
   assign cs_n_s   = ~syn[1];
   assign si_s     = syn[2];
   assign hold_n_s = ~syn[3];
   assign pf_s     = syn[4];

   spe_dev_st_t       st_q, st_d;
   logic              sck_p_q, sck_p_d;
   logic [7:0]        sh_q, sh_d;
   logic [2:0]        bit_q, bit_d;
   logic [7:0]        out_q, out_d;
   logic              so_q, so_d;
   logic              oe_n_q, oe_n_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic              hi_q, hi_d;
   logic              wr_q, wr_d;
   logic [7:0]        buf_q [PAGE];
   logic [7:0]        buf_d [PAGE];
   logic [PAGE-1:0]   mask_q, mask_d;
   logic              busy_q, busy_d;
   logic [TMR_W-1:0]  tmr_q, tmr_d;
   logic [7:0]        mem_q [DEPTH];
   logic              commit;
   logic              rise, fall;
   logic [7:0]        byte_in;
   logic [7:0]        stat;

   assign rise    = sck_s & ~sck_p_q;
   assign fall    = ~sck_s & sck_p_q;
   assign byte_in = {sh_q[6:0], si_s};
   assign stat    = {7'h00, busy_q};
   assign commit  = busy_q & (tmr_q == '0) & ~pf_s;

   always_comb begin
      st_d    = st_q;
      sck_p_d = sck_s;
      sh_d    = sh_q;
      bit_d   = bit_q;
      out_d   = out_q;
      so_d    = so_q;
      oe_n_d  = oe_n_q;
      addr_d  = addr_q;
      hi_d    = hi_q;
      wr_d    = wr_q;
      buf_d   = buf_q;
      mask_d  = mask_q;
      busy_d  = busy_q;
      tmr_d   = tmr_q;
      if (busy_q) begin
         if (tmr_q == '0) begin
            busy_d = 1'b0;
         end else begin
            tmr_d = tmr_q - 1'b1;
         end
      end
      if (pf_s) begin
         // Abandon everything, the pending page is lost
         st_d   = SPE_SB;
         oe_n_d = 1'b1;
         busy_d = 1'b0;
         mask_d = '0;
      end else if (cs_n_s) begin
         st_d   = SPE_SB;
         oe_n_d = 1'b1;
         if (st_q == SPE_WDAT && |mask_q && !busy_q) begin
            busy_d = 1'b1;
            tmr_d  = TMR_W'(WR_CYC - 1);
         end
      end else if (st_q == SPE_SB) begin
         st_d  = SPE_OPC;
         bit_d = '0;
      end else if (!hold_n_s) begin
         // Clock edges are ignored and the output floats
         oe_n_d = 1'b1;
      end else begin
         oe_n_d = !(st_q == SPE_RDAT || st_q == SPE_STAT);
         if (rise) begin
            sh_d  = byte_in;
            bit_d = bit_q + 1'b1;
            if (bit_q == 3'h7) begin
               unique case (st_q)
                  SPE_OPC: begin
                     if (busy_q) begin
                        st_d = (byte_in == OP_STATUS) ? SPE_STAT : SPE_IGN;
                        out_d = stat;
                     end else if (byte_in == OP_READ || byte_in == OP_WRITE) begin
                        st_d   = SPE_ADDR;
                        hi_d   = 1'b1;
                        wr_d   = (byte_in == OP_WRITE);
                        mask_d = '0;
                     end else if (byte_in == OP_STATUS) begin
                        st_d  = SPE_STAT;
                        out_d = stat;
                     end else begin
                        st_d = SPE_IGN;
                     end
                  end
                  SPE_ADDR: begin
                     if (hi_q) begin
                        addr_d[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
                        hi_d = 1'b0;
                     end else begin
                        addr_d[7:0] = byte_in;
                        st_d = wr_q ? SPE_WDAT : SPE_RDAT;
                        out_d = mem_q[{addr_q[ADDR_W-1:8], byte_in}];
                     end
                  end
                  SPE_WDAT: begin
                     buf_d[addr_q[PAGE_W-1:0]]  = byte_in;
                     mask_d[addr_q[PAGE_W-1:0]] = 1'b1;
                     // Stays within the page, wraps to its first byte
                     addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 1'b1;
                  end
                  SPE_RDAT: begin
                     addr_d = addr_q + 1'b1;
                     out_d  = mem_q[ADDR_W'(addr_q + 1'b1)];
                  end
                  SPE_STAT: begin
                     out_d = stat;
                  end
                  SPE_IGN, SPE_SB: begin
                  end
               endcase
            end
         end
         if (fall && (st_q == SPE_RDAT || st_q == SPE_STAT)) begin
            so_d  = out_q[7];
            out_d = {out_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= SPE_SB;
         sck_p_q <= 1'b0;
         sh_q    <= '0;
         bit_q   <= '0;
         out_q   <= '0;
         so_q    <= 1'b0;
         oe_n_q  <= 1'b1;
         addr_q  <= '0;
         hi_q    <= 1'b0;
         wr_q    <= 1'b0;
         mask_q  <= '0;
         busy_q  <= 1'b0;
         tmr_q   <= '0;
      end else begin
         st_q    <= st_d;
         sck_p_q <= sck_p_d;
         sh_q    <= sh_d;
         bit_q   <= bit_d;
         out_q   <= out_d;
         so_q    <= so_d;
         oe_n_q  <= oe_n_d;
         addr_q  <= addr_d;
         hi_q    <= hi_d;
         wr_q    <= wr_d;
         mask_q  <= mask_d;
         busy_q  <= busy_d;
         tmr_q   <= tmr_d;
      end
   end

   // Storage carries no reset, so it stays out of the reset block
   always_ff @(posedge clk_sys) begin
      buf_q <= buf_d;
   end

   always_ff @(posedge clk_sys) begin
      if (commit) begin
         for (int i = 0; i < PAGE; i++) begin
            if (mask_q[i]) begin
               mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= buf_q[i];
            end
         end
      end
   end

   assign lnk.so      = so_q;
   assign lnk.so_oe_n = oe_n_q;
   assign busy        = busy_q;
endmodule : spe_dev
`default_nettype wire

// ### inc/spe_pkg.sv
// Shared constants for the serial memory link and its two ends
`default_nettype none
package spe_pkg;
   localparam int          CLK_NS      = 4;          // clk_sys period
   localparam int          ADDR_W      = 14;
   localparam int          DEPTH       = 16384;
   localparam int          PAGE        = 128;
   localparam int          PAGE_W      = 7;
   localparam int          WR_MS       = 5;          // longest internal write
   localparam int          WR_CYC      = WR_MS * 1000000 / CLK_NS;
   localparam int          TMR_W       = 21;
   localparam int          SCK_HALF_NS = 32;         // host half period, above 25 ns
   localparam int          SCK_HALF    = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0]  OP_WRITE    = 8'h02;
   localparam logic [7:0]  OP_READ     = 8'h03;
   localparam logic [7:0]  OP_STATUS   = 8'h05;
   localparam int          BUSY_BIT    = 0;
   typedef enum logic [2:0] {
      SPE_SB, SPE_OPC, SPE_ADDR, SPE_WDAT, SPE_RDAT, SPE_STAT, SPE_IGN
   } spe_dev_st_t;
   typedef enum logic [1:0] {SPE_H_IDLE, SPE_H_LO, SPE_H_HI, SPE_H_END} spe_host_st_t;
endpackage : spe_pkg
`default_nettype wire

// ### inc/spe_if.sv
// Serial link wires between the memory end and the controller end
`default_nettype none
interface spe_if;
   logic sck;
   logic cs_n;
   logic si;
   logic hold_n;
   logic so;
   logic so_oe_n;
   modport dev  (input sck, input cs_n, input si, input hold_n, output so, output so_oe_n);
   modport host (output sck, output cs_n, output si, output hold_n, input so, input so_oe_n);
endinterface : spe_if
`default_nettype wire

// ### hw/spe_sync.sv
// Two-flop synchroniser, parameterised width
`default_nettype none
module spe_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : spe_sync
`default_nettype wire

// ### hw/spe_host.sv
// Controller end: makes the serial clock and frames commands
`default_nettype none
module spe_host (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Serial link
   spe_if.host             lnk,
   // Command
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_op,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [7:0] cmd_len,
   output logic            cmd_ready,
   // Data
   input  wire logic [7:0] tx_data,
   output logic            tx_take,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   // Pause
   input  wire logic       pause_req
);
   import spe_pkg::*;

   spe_host_st_t st_q, st_d;
   logic [7:0]   cnt_q, cnt_d;
   logic [2:0]   bit_q, bit_d;
   logic [7:0]   bidx_q, bidx_d;
   logic [7:0]   nbyte_q, nbyte_d;
   logic [7:0]   hdr_q, hdr_d;
   logic [7:0]   tx_q, tx_d;
   logic [7:0]   rx_q, rx_d;
   logic [15:0]  addr_q, addr_d;
   logic         sck_q, sck_d, cs_n_q, cs_n_d, mosi_q, mosi_d, hold_n_q, hold_n_d;
   logic [7:0]   rxo_q, rxo_d;
   logic         rxv_q, rxv_d, take_q, take_d;
   logic         rdy_q, rdy_d;
   logic         so_s;
   logic [7:0]   nxt;
   logic         has_addr;

   spe_sync #(.W(1)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (lnk.so),
      .q       (so_s)
   );

   assign has_addr = (cmd_op == OP_READ) || (cmd_op == OP_WRITE);

   always_comb begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      bit_d    = bit_q;
      bidx_d   = bidx_q;
      nbyte_d  = nbyte_q;
      hdr_d    = hdr_q;
      tx_d     = tx_q;
      rx_d     = rx_q;
      addr_d   = addr_q;
      sck_d    = sck_q;
      cs_n_d   = cs_n_q;
      mosi_d   = mosi_q;
      hold_n_d = hold_n_q;
      rxo_d    = rxo_q;
      rxv_d    = 1'b0;
      take_d   = 1'b0;
      nxt      = '0;
      unique case (st_q)
         SPE_H_IDLE: begin
            if (cmd_valid) begin
               cs_n_d  = 1'b0;
               hdr_d   = has_addr ? 8'h03 : 8'h01;
               nbyte_d = 8'(cmd_len + (has_addr ? 8'h03 : 8'h01));
               addr_d  = cmd_addr;
               mosi_d  = cmd_op[7];
               tx_d    = {cmd_op[6:0], 1'b0};
               bit_d   = '0;
               bidx_d  = '0;
               cnt_d   = 8'(SCK_HALF - 1);
               st_d    = SPE_H_LO;
            end
         end
         SPE_H_LO: begin
            if (pause_req) begin
               hold_n_d = 1'b0;
            end else if (!hold_n_q) begin
               hold_n_d = 1'b1;
            end else if (cnt_q == '0) begin
               sck_d = 1'b1;
               rx_d  = {rx_q[6:0], so_s};
               cnt_d = 8'(SCK_HALF - 1);
               st_d  = SPE_H_HI;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         SPE_H_HI: begin
            if (cnt_q == '0) begin
               sck_d = 1'b0;
               cnt_d = 8'(SCK_HALF - 1);
               bit_d = bit_q + 1'b1;
               st_d  = SPE_H_LO;
               if (bit_q == 3'h7) begin
                  if (bidx_q >= hdr_q) begin
                     rxo_d = rx_q;
                     rxv_d = 1'b1;
                  end
                  if (bidx_q + 8'h01 == nbyte_q) begin
                     st_d = SPE_H_END;
                  end else begin
                     bidx_d = bidx_q + 1'b1;
                     if (bidx_q == 8'h00 && hdr_q == 8'h03) begin
                        nxt = addr_q[15:8];
                     end else if (bidx_q == 8'h01 && hdr_q == 8'h03) begin
                        nxt = addr_q[7:0];
                     end else begin
                        nxt    = tx_data;
                        take_d = 1'b1;
                     end
                     mosi_d = nxt[7];
                     tx_d   = {nxt[6:0], 1'b0};
                  end
               end else begin
                  mosi_d = tx_q[7];
                  tx_d   = {tx_q[6:0], 1'b0};
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         SPE_H_END: begin
            if (cnt_q == '0) begin
               cs_n_d = 1'b1;
               st_d   = SPE_H_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
      endcase
      // Ready leaves a flop, one cycle behind nothing: it tracks the next state
      rdy_d = (st_d == SPE_H_IDLE);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= SPE_H_IDLE;
         cnt_q    <= '0;
         bit_q    <= '0;
         bidx_q   <= '0;
         nbyte_q  <= '0;
         hdr_q    <= '0;
         tx_q     <= '0;
         rx_q     <= '0;
         addr_q   <= '0;
         sck_q    <= 1'b0;
         cs_n_q   <= 1'b1;
         mosi_q   <= 1'b0;
         hold_n_q <= 1'b1;
         rxo_q    <= '0;
         rxv_q    <= 1'b0;
         take_q   <= 1'b0;
         rdy_q    <= 1'b1;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         bit_q    <= bit_d;
         bidx_q   <= bidx_d;
         nbyte_q  <= nbyte_d;
         hdr_q    <= hdr_d;
         tx_q     <= tx_d;
         rx_q     <= rx_d;
         addr_q   <= addr_d;
         sck_q    <= sck_d;
         cs_n_q   <= cs_n_d;
         mosi_q   <= mosi_d;
         hold_n_q <= hold_n_d;
         rxo_q    <= rxo_d;
         rxv_q    <= rxv_d;
         take_q   <= take_d;
         rdy_q    <= rdy_d;
      end
   end

   assign cmd_ready  = rdy_q;
   assign tx_take    = take_q;
   assign rx_data    = rxo_q;
   assign rx_valid   = rxv_q;
   assign lnk.sck    = sck_q;
   assign lnk.cs_n   = cs_n_q;
   assign lnk.si     = mosi_q;
   assign lnk.hold_n = hold_n_q;
endmodule : spe_host
`default_nettype wire

// ### bench/spe_props.sv
// Link wire checker for the serial memory pair
`default_nettype none
module spe_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic so,
   input wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_sck_idle; cs_n |-> !sck; endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("serial clock high while deselected");
   property p_cs_lead; $fell(cs_n) |-> !sck [*8]; endproperty
   a_cs_lead: assert property (p_cs_lead)
      else $error("first clock rise too soon after select");
   property p_sck_half; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
   a_sck_half: assert property (p_sck_half)
      else $error("serial clock high phase not eight cycles");
   property p_si_hold; sck && $past(sck) |-> $stable(si); endproperty
   a_si_hold: assert property (p_si_hold)
      else $error("data in moved while clock high");
   // Fall reaches the memory after its synchroniser, so look two cycles back
   property p_so_fall;
      !so_oe_n && !$past(so_oe_n) && $changed(so) |-> !$past(sck) && !$past(sck, 2);
   endproperty
   a_so_fall: assert property (p_so_fall)
      else $error("data out moved outside clock low phase");
   property p_oe_idle; cs_n [*5] |-> so_oe_n; endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("data out driven while deselected");
   property p_hold_chg; $changed(hold_n) |-> !sck && !$past(sck); endproperty
   a_hold_chg: assert property (p_hold_chg)
      else $error("pause moved around a clock edge");
   property p_hold_sck; !hold_n |-> !sck; endproperty
   a_hold_sck: assert property (p_hold_sck)
      else $error("serial clock ran during pause");
   property p_hold_oe; !hold_n [*5] |-> so_oe_n; endproperty
   a_hold_oe: assert property (p_hold_oe)
      else $error("data out driven during pause");
   c_frame: cover property ($fell(cs_n));
   c_pause: cover property ($fell(hold_n));
   c_drive: cover property ($fell(so_oe_n));
endmodule : spe_props
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench joining both ends of the serial memory link
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import spe_pkg::*;
   // Short write time, yet long enough to cover a status frame and a refused write
   localparam int WRC = 1000;
   logic clk_sys = 1'b0, rst_n = 1'b0, pwr_fail = 1'b0, busy;
   logic cmd_valid = 1'b0, cmd_ready, tx_take, rx_valid, pause_req = 1'b0;
   logic [7:0] cmd_op = 8'h00, cmd_len = 8'h00, tx_data = 8'h00, rx_data;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] wbuf[$], rxq[$];
   logic sib[$];
   int txi = 0, hold_seen = 0, fail_count = 0, samples_checked = 0;
   spe_if lnk ();
   spe_dev #(.WR_CYC(WRC)) u_spe_dev (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk),
      .pwr_fail(pwr_fail), .busy(busy));
   spe_host u_spe_host (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
      .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
      .pause_req(pause_req));
   spe_props u_spe_props (.clk_sys(clk_sys), .rst_n(rst_n), .sck(lnk.sck), .cs_n(lnk.cs_n),
      .si(lnk.si), .hold_n(lnk.hold_n), .so(lnk.so), .so_oe_n(lnk.so_oe_n));
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (tx_take) txi++;
      tx_data <= (txi < wbuf.size()) ? wbuf[txi] : 8'h00;
      if (rx_valid) rxq.push_back(rx_data);
      if (!lnk.hold_n) hold_seen++;
   end
   // Wire view of what the memory samples
   always @(posedge lnk.sck) if (!lnk.cs_n) sib.push_back(lnk.si);
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [7:0] n);
      logic [23:0] h;
      int k;
      rxq.delete();
      sib.delete();
      txi = 0;
      h = '0;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_valid <= 1'b1;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (k = 0; k < 9000 && cmd_ready !== 1'b1; k++) @(posedge clk_sys);
      // Short frames are padded so the opcode always lands in the top byte
      for (k = 0; k < 24; k++) h = {h[22:0], (k < sib.size()) ? sib[k] : 1'b0};
      chk(h[23:16], op);
      if (op != OP_STATUS) chk(h[15:0] == a, 8'h01);
      chk(8'(rxq.size()), n);
   endtask : cmd
   task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
      cmd(OP_READ, a, 8'(e.size()));
      foreach (e[i]) chk(rxq[i], e[i]);
   endtask : rd
   task automatic wdone(input bit timed);
      int k;
      repeat (6) @(posedge clk_sys);
      chk(busy, 8'h01);
      for (k = 0; k < WRC + 100 && busy !== 1'b0; k++) @(posedge clk_sys);
      chk(busy, 8'h00);
      if (timed) chk(8'(k > WRC - 15 && k <= WRC), 8'h01);
   endtask : wdone
   task automatic t_partial;
      wbuf = '{8'hA0, 8'hA1, 8'hA2, 8'hA3};
      cmd(OP_WRITE, 16'h0100, 8'h04);
      wdone(1'b1);
      wbuf = '{8'h11, 8'h22};
      cmd(OP_WRITE, 16'hC101, 8'h02);
      wdone(1'b0);
      rd(16'h0100, '{8'hA0, 8'h11, 8'h22, 8'hA3});
   endtask : t_partial
   task automatic t_wrap;
      wbuf = '{8'h5A, 8'h6B};
      cmd(OP_WRITE, 16'h017F, 8'h02);
      wdone(1'b0);
      rd(16'h017F, '{8'h5A});
      rd(16'h0100, '{8'h6B});
   endtask : t_wrap
   task automatic t_busy;
      // Status frame and the refused write both sit inside one write time
      wbuf = '{8'h77};
      cmd(OP_WRITE, 16'h0200, 8'h01);
      cmd(OP_STATUS, 16'h0000, 8'h02);
      chk(rxq[0], 8'h01);
      chk(rxq[1], 8'h01);
      cmd(OP_WRITE, 16'h0100, 8'h01);
      wdone(1'b0);
      cmd(OP_STATUS, 16'h0000, 8'h01);
      chk(rxq[0], 8'h00);
      rd(16'h0100, '{8'h6B});
      rd(16'h0200, '{8'h77});
   endtask : t_busy
   task automatic t_pause;
      hold_seen = 0;
      fork
         rd(16'h0100, '{8'h6B, 8'h11});
         begin
            // Lands in the first data byte, while the memory drives its output
            repeat (450) @(posedge clk_sys);
            pause_req <= 1'b1;
            repeat (60) @(posedge clk_sys);
            pause_req <= 1'b0;
         end
      join
      chk(8'(hold_seen > 20), 8'h01);
   endtask : t_pause
   task automatic t_pwr;
      wbuf = '{8'hC3};
      cmd(OP_WRITE, 16'h0100, 8'h01);
      repeat (20) @(posedge clk_sys);
      pwr_fail <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk(busy, 8'h00);
      cmd(OP_WRITE, 16'h0100, 8'h01);
      repeat (8) @(posedge clk_sys);
      chk(busy, 8'h00);
      pwr_fail <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(16'h0100, '{8'h6B});
   endtask : t_pwr
   task automatic t_reset;
      cmd_op <= OP_READ;
      cmd_addr <= 16'h0100;
      cmd_len <= 8'h02;
      cmd_valid <= 1'b1;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      repeat (40) @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(lnk.cs_n, 8'h01);
      chk(lnk.so_oe_n, 8'h01);
      chk(busy, 8'h00);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rd(16'h0100, '{8'h6B, 8'h11});
   endtask : t_reset
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_partial();
      t_wrap();
      t_busy();
      t_pause();
      t_pwr();
      t_reset();
      tally_and_finish();
   end
   // Run needs about 13000 cycles; stop a hang well past that
   initial begin
      repeat (30000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
